// ### rtl/fcl_defs.vh
// Shared constants for the configuration load port
`ifndef FCL_DEFS_VH
`define FCL_DEFS_VH
// Mode pin codes, packed as {mode_select_2, mode_select_1, mode_select_0}
`define FCL_MODE_PAR_UP 3'h4
`define FCL_MODE_PAR_DN 3'h6
`define FCL_MODE_SER_MS 3'h0
`define FCL_MODE_PERIPH 3'h5
`define FCL_MODE_SLAVE 3'h7
// Address start points
`define FCL_ADDR_UP_START 18'h00000
`define FCL_ADDR_DN_START_S 18'h0FFFF
`define FCL_ADDR_DN_START_L 18'h3FFFF
// Header lengths in bits
`define FCL_HDR_BITS_STD 6'h28
`define FCL_HDR_BITS_EXT 6'h30
// Length counter width
`define FCL_LEN_BITS 24
// Configuration clock divider: half period in mclk cycles
`define FCL_CONFIG_CLOCK_HALF 4'h4
// Power-up wait before ready, in ms, and cycles at 25 MHz
`define FCL_WAKE_MS 34
`define FCL_WAKE_CYC (`FCL_WAKE_MS * 25000)
`endif

// ### rtl/fcl_sync3.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module fcl_sync3 #(
  parameter W = 1
) (
  input wire mclk, // System clock
  input wire sys_rst, // Asynchronous reset, active high
  input wire [W-1:0] async_in, // Input from outside the clock domain
  output reg [W-1:0] sync_out // Filtered level
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;

  // First stage feeds only the second; output moves when stages two and three agree
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      sync_out <= (s2_q & s3_q) | (sync_out & (s2_q | s3_q));
    end
  end
endmodule // fcl_sync3

// ### rtl/fcl_load_port.v
// Configuration load port: mode select, PROM fetch, peripheral, serial, daisy chain
`timescale 1ns/1ps
`include "fcl_defs.vh"
// Notes on behaviour
// - Mode pins choose one of five load methods
// - Parallel up starts zero; down starts all-ones
// - Drive address bus, read byte bus in parallel
// - Master serial drives clock; PROM returns serial data
// - Accept byte only with chip select and strobe
// - Byte bit n arrives on data pin n
// - Serial legacy data LSB first, length MSB
// - Ready pin held low until modes sampled
// - User I/O activation timing is programmable
// - Later chain devices run slave serial mode
// - Emit 40/48-bit header on serial output
// - Early done option for mixed-family slaves
// - Output high after header until own data done
// - Count every config clock rise after init high
// - Done only when count equals stored length
module fcl_load_port #(
  parameter ADDR_W = 18, // Address counter width
  parameter LARGE_FAMILY = 1, // 1: down mode starts at 3FFFF, else FFFF
  parameter WAKE_CYC = `FCL_WAKE_CYC // Power-up wait in mclk cycles
) (
  input wire mclk, // 25 MHz system clock
  input wire sys_rst, // Asynchronous reset, active high
  input wire mode_select_0, // Mode pin 0
  input wire mode_select_1, // Mode pin 1
  input wire mode_select_2, // Mode pin 2
  input wire ext_header, // 1: emit 48-bit header, else 40-bit
  input wire early_done, // 1: done and I/O before final clocks
  input wire [`FCL_LEN_BITS-1:0] length_count, // Stored length-count value
  input wire config_clock_in, // Configuration clock pin input (slave)
  output reg config_clock_out, // Configuration clock driven (master)
  output reg config_clock_oe, // High while driving config clock
  input wire serial_din, // Serial data input
  output reg serial_dout, // Serial daisy-chain output
  input wire [7:0] config_byte_bus, // Parallel data bus
  output reg [15:0] prom_address_bus, // PROM address low bits
  output reg [ADDR_W-17:0] prom_address_hi, // PROM address upper bits
  output reg prom_address_oe, // High while address bus is driven
  input wire periph_cs_n, // Peripheral chip select, active low
  input wire periph_wr_n, // Peripheral write strobe, active low
  output reg ready_busy, // Ready (high) / busy (low)
  output reg init_status, // Initialisation done, high when ready
  output reg low_during_config_n, // Low during configuration
  output reg done, // Configuration done
  output reg user_io_en // User I/O activated
);
  // One-hot states
  localparam S_WAKE = 5'h01;
  localparam S_IDLE = 5'h02;
  localparam S_LOAD = 5'h04;
  localparam S_START = 5'h08;
  localparam S_FIN = 5'h10;

  wire [2:0] mode_s;
  wire config_clock_s;
  wire din_s;
  wire cs_n_s;
  wire wr_n_s;
  wire [7:0] byte_s;

  // All pins cross from outside mclk: three modes, clock, data, two strobes, byte
  // The byte may use plain per-bit stages because it stands still around its strobe
  fcl_sync3 #(.W(15)) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_in({mode_select_2, mode_select_1, mode_select_0, config_clock_in,
      serial_din, periph_cs_n, periph_wr_n, config_byte_bus}),
    .sync_out({mode_s, config_clock_s, din_s, cs_n_s, wr_n_s, byte_s})
  );

  reg [4:0] state_q;
  reg [2:0] mode_q;
  reg [22:0] wake_q;
  reg [3:0] div_q;
  reg config_clock_q;
  reg config_clock_prev_q;
  reg [`FCL_LEN_BITS-1:0] count_q;
  reg [5:0] hdr_q;
  reg [ADDR_W-1:0] addr_q;
  reg [7:0] shift_q;
  reg [3:0] nbits_q;
  reg wr_prev_q;
  reg own_done_q;
  reg [2:0] start_q;

  wire is_par = (mode_q == `FCL_MODE_PAR_UP) || (mode_q == `FCL_MODE_PAR_DN);
  wire is_per = (mode_q == `FCL_MODE_PERIPH);
  wire is_slave = (mode_q == `FCL_MODE_SLAVE);
  wire is_master = !is_slave && !is_per;
  wire [ADDR_W-1:0] dn_start = LARGE_FAMILY ? `FCL_ADDR_DN_START_L : `FCL_ADDR_DN_START_S;

  // Local clock divider runs as a master only in the load and start-up states
  wire run_clk = is_master && (state_q == S_LOAD || state_q == S_START);
  wire half_tick = (div_q == `FCL_CONFIG_CLOCK_HALF - 4'h1);
  // Peripheral modes also step the converter from the internal divider
  wire int_rise = half_tick && !config_clock_q && (run_clk || (is_per && nbits_q != 4'h0));
  wire ext_rise = is_slave && config_clock_s && !config_clock_prev_q;
  wire rise = is_slave ? ext_rise : int_rise;

  // Serial bit this clock: direct pin, or converter LSB-first shift
  wire cur_bit = (is_par || is_per) ? shift_q[0] : din_s;
  wire len_match = (count_q == length_count);
  wire [5:0] hdr_len = ext_header ? `FCL_HDR_BITS_EXT : `FCL_HDR_BITS_STD;
  wire wr_done = is_per && !cs_n_s && wr_n_s && !wr_prev_q;

  // Clock divider and edge tracking
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      div_q <= 4'h0;
      config_clock_q <= 1'b0;
      config_clock_prev_q <= 1'b0;
    end else begin
      config_clock_prev_q <= config_clock_s;
      if (half_tick) begin
        div_q <= 4'h0;
      end else begin
        div_q <= div_q + 4'h1;
      end
      if (half_tick && (run_clk || is_per)) begin
        config_clock_q <= ~config_clock_q;
      end else if (!run_clk && !is_per) begin
        config_clock_q <= 1'b0;
      end
    end
  end

  // Write strobe history for the rising-edge detector
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_prev_q <= 1'b1;
    end else begin
      wr_prev_q <= wr_n_s;
    end
  end

  // Main sequencer
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= S_WAKE;
      mode_q <= `FCL_MODE_SLAVE;
      wake_q <= 23'h000000;
      count_q <= {`FCL_LEN_BITS{1'b0}};
      hdr_q <= 6'h00;
      addr_q <= {ADDR_W{1'b0}};
      shift_q <= 8'h00;
      nbits_q <= 4'h0;
      own_done_q <= 1'b0;
      start_q <= 3'h0;
    end else begin
      case (state_q)
        S_WAKE: begin
          // Wait out power-up, then latch mode pins once
          if (wake_q == WAKE_CYC[22:0]) begin
            mode_q <= mode_s;
            addr_q <= (mode_s == `FCL_MODE_PAR_DN) ? dn_start : `FCL_ADDR_UP_START;
            state_q <= S_IDLE;
          end else begin
            wake_q <= wake_q + 23'h000001;
          end
        end
        S_IDLE: begin
          // Init goes high as this state is left; header counter starts fresh
          state_q <= S_LOAD;
          count_q <= {`FCL_LEN_BITS{1'b0}};
          hdr_q <= 6'h00;
        end
        S_LOAD: begin
          // Load a new byte into the converter when it is empty
          if (is_par && nbits_q == 4'h0 && half_tick && !config_clock_q) begin
            shift_q <= byte_s;
            nbits_q <= 4'h8;
            if (mode_q == `FCL_MODE_PAR_DN) begin
              addr_q <= addr_q - {{(ADDR_W-1){1'b0}}, 1'b1};
            end else begin
              addr_q <= addr_q + {{(ADDR_W-1){1'b0}}, 1'b1};
            end
          end else if (wr_done && nbits_q == 4'h0) begin
            shift_q <= byte_s;
            nbits_q <= 4'h8;
          end else if (rise) begin
            if ((is_par || is_per) && nbits_q != 4'h0) begin
              shift_q <= {1'b0, shift_q[7:1]};
              nbits_q <= nbits_q - 4'h1;
            end
          end
          if (rise) begin
            count_q <= count_q + {{(`FCL_LEN_BITS-1){1'b0}}, 1'b1};
            if (hdr_q != hdr_len) begin
              hdr_q <= hdr_q + 6'h01;
            end
            if (len_match) begin
              own_done_q <= 1'b1;
              state_q <= S_START;
            end
          end
        end
        S_START: begin
          // A few further clocks to run start-up
          if (rise) begin
            start_q <= start_q + 3'h1;
            if (start_q == 3'h3) begin
              state_q <= S_FIN;
            end
          end
        end
        S_FIN: begin
          // Only a reset leaves here; the local clock is parked low meanwhile, except in peripheral mode where it keeps toggling
          state_q <= S_FIN;
        end
        default: begin
          state_q <= S_WAKE;
        end
      endcase
    end
  end

  // Configuration clock pin; released in slave and peripheral modes
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      config_clock_out <= 1'b0;
      config_clock_oe <= 1'b0;
    end else begin
      config_clock_out <= config_clock_q;
      config_clock_oe <= is_master && state_q != S_WAKE;
    end
  end

  // Status pins; init also resets the serial PROM, so it drops on every restart
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      init_status <= 1'b0;
      low_during_config_n <= 1'b1;
    end else begin
      init_status <= state_q != S_WAKE;
      low_during_config_n <= !(state_q == S_LOAD || state_q == S_START);
    end
  end

  // PROM address pins; released at the match so user logic may take them over
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prom_address_bus <= 16'h0000;
      prom_address_hi <= {(ADDR_W-16){1'b0}};
      prom_address_oe <= 1'b0;
    end else begin
      prom_address_bus <= addr_q[15:0];
      prom_address_hi <= addr_q[ADDR_W-1:16];
      prom_address_oe <= is_par && state_q == S_LOAD;
    end
  end

  // Ready stays low until the mode is known, so no false ready after power-up
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ready_busy <= 1'b0;
    end else begin
      ready_busy <= is_per && state_q == S_LOAD && nbits_q == 4'h0 && !wr_done;
    end
  end

  // Header goes out ahead of data, then high, then pass-through
  // Idle level is high so a downstream device sees no start bit before the header
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      serial_dout <= 1'b1;
    end else begin
      if (rise && state_q == S_LOAD) begin
        if (hdr_q != hdr_len) begin
          serial_dout <= cur_bit;
        end else begin
          serial_dout <= 1'b1;
        end
      end else if (rise && own_done_q) begin
        serial_dout <= cur_bit;
      end
    end
  end

  // Early option raises done and I/O at the match; both hold until reset
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      done <= 1'b0;
      user_io_en <= 1'b0;
    end else begin
      if (early_done && own_done_q) begin
        done <= 1'b1;
        user_io_en <= 1'b1;
      end else if (state_q == S_FIN) begin
        done <= 1'b1;
        user_io_en <= 1'b1;
      end
    end
  end
endmodule // fcl_load_port

// ### testbench/fcl_load_port_properties.sv
// Pin relation checker for the configuration load port
`timescale 1ns/1ps
module fcl_chk (
  input wire mclk, // Clock
  input wire sys_rst, // Reset
  input wire mode_select_0, // Mode 0
  input wire mode_select_1, // Mode 1
  input wire mode_select_2, // Mode 2
  input wire config_clock_oe, // Clock drive
  input wire serial_dout, // Chain out
  input wire [15:0] prom_address_bus, // Address
  input wire prom_address_oe, // Address drive
  input wire ready_busy, // Ready
  input wire init_status, // Init
  input wire done // Done
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // One address step per fetch, direction set by the mode
  property p_step(logic dn);
    prom_address_oe && $past(prom_address_oe) && mode_select_1 == dn &&
      $changed(prom_address_bus) |->
      prom_address_bus == $past(prom_address_bus) + (dn ? 16'hFFFF : 16'h1);
  endproperty
  a_addr_up: assert property (p_step(1'h0)) else $error("Bad up step");
  a_addr_dn: assert property (p_step(1'h1)) else $error("Bad down step");
  a_addr_mode: assert property (prom_address_oe |-> mode_select_2 && !mode_select_0)
    else $error("Address driven in wrong mode");
  a_slave_clk: assert property (mode_select_0 && mode_select_1 && mode_select_2
    |-> !config_clock_oe) else $error("Slave drives clock");
  a_ready_early: assert property (!init_status |-> !ready_busy)
    else $error("Ready before init");
  a_dout_idle: assert property (!init_status |-> serial_dout)
    else $error("Chain output not high");
  a_done_stop: assert property (done && $past(done, 2) |-> !prom_address_oe)
    else $error("Address still driven");
  a_done_hold: assert property (done |=> done) else $error("Done dropped");
  c_done: cover property ($rose(done));
  c_busy: cover property ($fell(ready_busy));
  c_fetch: cover property ($rose(prom_address_oe));
endmodule // fcl_chk
bind fcl_load_port fcl_chk u_chk (.mclk(mclk), .sys_rst(sys_rst),
  .mode_select_0(mode_select_0), .mode_select_1(mode_select_1),
  .mode_select_2(mode_select_2), .config_clock_oe(config_clock_oe),
  .serial_dout(serial_dout), .prom_address_bus(prom_address_bus),
  .prom_address_oe(prom_address_oe), .ready_busy(ready_busy),
  .init_status(init_status), .done(done));

// ### testbench/fcl_src_model.sv
// Source model: parallel PROM, serial PROM or upstream chain device
`timescale 1ns/1ps
module fcl_src_model (
  input wire config_clock, // Clock on the pin
  input wire prom_rst_n, // PROM reset, from init status
  input wire prom_sel_n, // PROM enable, from low-during-config
  input wire [15:0] addr, // Fetch address
  output wire [7:0] byte_out, // Parallel data
  output wire bit_out // Serial data
);
  reg [7:0] pat_q; // Rotating serial pattern
  // Pattern reloaded with B4 while init is low, so an abort restarts the PROM too
  always @(posedge config_clock or negedge prom_rst_n) begin
    if (!prom_rst_n) begin
      pat_q <= 8'hB4;
    end else begin
      pat_q <= {pat_q[0], pat_q[7:1]};
    end
  end
  assign bit_out = pat_q[0];
  // Deselected PROM shows a toggling pattern, never stale data
  assign byte_out = prom_sel_n ? {4{config_clock, ~config_clock}} : addr[7:0] ^ 8'hA5;
endmodule // fcl_src_model

// ### testbench/fcl_load_port_tb.sv
// Self-checking bench for the configuration load port
`timescale 1ns/1ps
`include "fcl_defs.vh"
module fcl_load_port_tb;
  localparam [23:0] LEN = 24'h40;
  reg mclk, sys_rst, sclk, cs_n, wr_n, sclk_on, pdrv, ext_hdr, early, hdr_low;
  reg [2:0] mode;
  reg [7:0] pbyte;
  wire cko, cko_oe, sdin, rdy, init, ldc_n, done, a_oe, dout, uio;
  wire [15:0] addr;
  wire [1:0] addr_hi;
  wire [7:0] mbyte;
  int err_total, compares, cc;
  // Pin level of the clock: a master drives it, else the bench
  wire config_clock = cko_oe ? cko : sclk;
  wire [7:0] bus = pdrv ? pbyte : mbyte;
  fcl_load_port #(.WAKE_CYC(20)) u_fcl_load_port (.mclk(mclk), .sys_rst(sys_rst),
    .mode_select_0(mode[0]), .mode_select_1(mode[1]), .mode_select_2(mode[2]),
    .ext_header(ext_hdr), .early_done(early), .length_count(LEN), .config_clock_in(sclk),
    .config_clock_out(cko), .config_clock_oe(cko_oe), .serial_din(sdin), .serial_dout(dout),
    .config_byte_bus(bus), .prom_address_bus(addr), .prom_address_hi(addr_hi),
    .prom_address_oe(a_oe), .periph_cs_n(cs_n), .periph_wr_n(wr_n), .ready_busy(rdy),
    .init_status(init), .low_during_config_n(ldc_n), .done(done), .user_io_en(uio));
  fcl_src_model u_fcl_src_model (.config_clock(config_clock), .prom_rst_n(init), .prom_sel_n(ldc_n),
    .addr(addr), .byte_out(mbyte), .bit_out(sdin));
  // System clock, 40 ns
  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end
  // Link clock, 320 ns, off phase; stands low between frames
  initial begin
    #7;
    forever #160 sclk = sclk_on ? ~sclk : 1'h0;
  end
  // Clock rises seen since init went high
  always @(posedge config_clock or posedge sys_rst) cc <= sys_rst ? 0 : cc + init;
  // Any low level on the chain output during the first 40 clock rises of the header
  always @(negedge mclk) hdr_low <= !sys_rst && (hdr_low || (init && cc < 40 && dout === 1'h0));
  task automatic report_and_stop;
    $display("Compares %0d, errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", s, exp, seen);
    end
  endtask
  // Settled sampling point with a hang limit
  task automatic step(inout int n);
    @(negedge mclk);
    n++;
    if (n > 4000) begin
      err_total++;
      report_and_stop();
    end
  endtask
  task automatic restart(input [2:0] m, input logic x);
    int n;
    @(posedge mclk);
    sys_rst <= 1'h1;
    mode <= m;
    ext_hdr <= x;
    early <= !x;
    repeat (6) @(posedge mclk);
    chk("ready in reset", rdy, 0);
    sys_rst <= 1'h0;
    n = 0;
    while (init !== 1'h1) step(n);
  endtask
  task automatic run_done(input string s);
    int n;
    n = 0;
    while (cc < 56) step(n);
    chk("chain out high", dout, 1);
    chk("header bits seen", hdr_low, 1);
    while (done !== 1'h1) step(n);
    chk(s, cc >= LEN && cc <= LEN + 8, 1);
    chk("done timing", cc > LEN + 2, !early);
    chk("user io", uio, 1);
  endtask
  task automatic t_par(input [2:0] m, input [15:0] a0, input [15:0] a1, input [1:0] h);
    int n;
    // Down mode also runs the long header and the late done option
    restart(m, m[1]);
    n = 0;
    while (a_oe !== 1'h1) step(n);
    chk("first address", {addr_hi, addr}, {h, a0});
    while (addr === a0) step(n);
    chk("next address", addr, a1);
    run_done("fetch count");
    step(n);
    step(n);
    chk("address released", a_oe, 0);
  endtask
  task automatic t_serial(input [2:0] m, input logic own);
    restart(m, !own);
    sclk_on = !own;
    run_done("serial count");
    chk("clock drive", cko_oe, own);
    sclk_on = 1'h0;
  endtask
  // Selected writes make the port busy; unselected ones are ignored
  task automatic wr(input logic c, input [7:0] b);
    int n;
    @(posedge mclk);
    cs_n <= c;
    pbyte <= b;
    wr_n <= 1'h0;
    repeat (5) @(posedge mclk);
    wr_n <= 1'h1;
    n = 0;
    while (rdy === 1'h1 && n < 10) step(n);
    chk("ready after write", rdy, c);
    @(posedge mclk);
    cs_n <= 1'h1;
    n = 0;
    while (rdy !== 1'h1) step(n);
    if (!c) chk("last bit out", dout, b[7]);
  endtask
  task automatic t_periph;
    int n;
    restart(`FCL_MODE_PERIPH, 1'h0);
    @(posedge mclk);
    pdrv <= 1'h1;
    n = 0;
    while (rdy !== 1'h1) step(n);
    wr(1'h1, 8'h3C);
    wr(1'h0, 8'h01);
    wr(1'h0, 8'h80);
    @(posedge mclk);
    pdrv <= 1'h0;
  endtask
  initial begin
    {sys_rst, sclk, cs_n, wr_n, sclk_on, pdrv} = 6'h2C;
    {ext_hdr, early} = 2'h1;
    mode = 3'h0;
    pbyte = 8'h00;
    t_par(`FCL_MODE_PAR_UP, 16'h0000, 16'h0001, 2'h0);
    t_par(`FCL_MODE_PAR_DN, 16'hFFFF, 16'hFFFE, 2'h3);
    t_serial(`FCL_MODE_SER_MS, 1'h1);
    t_serial(`FCL_MODE_SLAVE, 1'h0);
    t_periph();
    report_and_stop();
  end
endmodule // fcl_load_port_tb
